// ==== logic/fcdl_pkg.sv ====
/*
 * fcdl_pkg: constants, modes and carriers for the fast comm data lanes.
 * Assumes a single 125 MHz core clock; link clocks are sampled, not used as clocks.
 */
package fcdl_pkg;
    // ==========================================================
    // line modes and carriers
    typedef enum logic [1:0] {
        FCDL_MODE_UTOPIA,
        FCDL_MODE_NIBBLE,
        FCDL_MODE_SERIAL
    } fcdl_mode_e;

    typedef struct packed {
        logic [7:0] data;   // octet, bit 7 most significant
        logic       first;  // first octet of an atm cell
    } fcdl_octet_s;

    typedef struct packed {
        logic [4:0] sub_block; // requester sub-block code
        logic       dir_rx;    // 0 transmit, 1 receive
    } fcdl_dma_id_s;

    // ==========================================================
    // sizes, counts and reset values
    localparam int         FCDL_FIFO_WIDTH   = 8;
    localparam int         FCDL_FIFO_DEPTH   = 16;
    localparam logic [5:0] FCDL_CELL_LAST    = 6'h34;  // 53 octets: index 0..52
    localparam logic [5:0] FCDL_CELL_FIRST   = 6'h00;
    localparam logic [7:0] FCDL_IDLE_OCTET   = 8'h00;  // fill octet of idle cells
    localparam logic [2:0] FCDL_STEP_NIBBLE  = 3'h4;
    localparam logic [2:0] FCDL_STEP_SERIAL  = 3'h1;
    localparam logic [7:0] FCDL_RST_OCTET    = 8'h00;
    localparam logic [5:0] FCDL_RST_DMA_NUM  = 6'h00;
    localparam int         FCDL_DMA_DIR_BIT  = 5;
endpackage : fcdl_pkg

// ==== logic/fcdl_lanes.sv ====
/*
 * fcdl_fifo and fcdl_lanes: data lanes of a fast comm channel (utopia octets,
 * nibble and single-bit modes) plus the dma requester number output.
 * Assumes line_mode is fixed before traffic and link clocks are slow against
 * the 125 MHz core clock, so each link edge is seen after synchronisation.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// fifo with valid/ready on both sides
module fcdl_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clock,    // core clock
    input  wire logic         sys_rst,  // sync reset, high
    input  wire logic         ce,       // clock enable
    input  wire logic         in_valid, // write request
    output logic              in_ready, // not full
    input  wire logic [W-1:0] in_data,  // write word
    output logic              out_valid,// not empty
    input  wire logic         out_ready,// read accept
    output logic      [W-1:0] out_data  // head word
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic [AW:0]  next_wr_ptr;
    logic [AW:0]  next_rd_ptr;
    logic         do_wr;
    logic         do_rd;

    // full and empty from pointer wrap bit
    always_comb begin
        in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(D);
        out_valid   = wr_ptr != rd_ptr;
        out_data    = mem[rd_ptr[AW-1:0]];
        do_wr       = in_valid && in_ready;
        do_rd       = out_valid && out_ready;
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    end

    // pointer and storage registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            if (do_wr) begin
                mem[wr_ptr[AW-1:0]] <= in_data;
            end
        end
    end
endmodule : fcdl_fifo

// Functional notes
// - utopia transmit sends one octet per transfer on eight lines, line 7 msb.
// - with no payload queued the utopia transmitter sends idle cells.
// - every atm cell on either bus is exactly 53 octets, one per transfer.
// - utopia receive takes one octet per transfer from eight lines, line 7 msb.
// - nibble modes transmit four bits per transfer on lines 3..0, line 3 msb.
// - nibble modes receive four bits per transfer on lines 3..0, line 3 msb.
// - serial modes move one bit per bit period on one line each way.
// - the dma requester number carries the sub-block code in bits 0..4.
// - bit 5 of the dma requester number is 0 for transmit and 1 for receive.
// - the requester number of a failing dma transfer is captured for error report.
// - with receive enable seen, data and start of cell are sampled one cycle later.
// - the start-of-cell output marks the first valid octet of a received cell.
// - in nibble mode transmit enable is high while frame data goes out.
module fcdl_lanes
    import fcdl_pkg::*;
(
    input  wire logic         clock,        // core clock 125 MHz
    input  wire logic         sys_rst,      // sync reset, high
    input  wire logic         ce,           // clock enable
    input  wire fcdl_mode_e   line_mode,    // static line mode
    input  wire logic         tx_in_valid,  // user octet valid
    output logic              tx_in_ready,  // fifo has room
    input  wire logic [7:0]   tx_in_data,   // user octet
    input  wire logic         tx_link_clk,  // transmit link clock pin
    output logic      [7:0]   tx_data,      // transmit data lines
    output logic              tx_soc,       // transmit start of cell
    output logic              tx_en,        // transmit enable
    input  wire logic         rx_link_clk,  // receive link clock pin
    input  wire logic [7:0]   rx_data,      // receive data lines
    input  wire logic         rx_enb_n,     // receive enable, low
    input  wire logic         rx_soc,       // receive start of cell pin
    input  wire logic         rx_dv,        // nibble receive data valid
    output logic              rx_soc_out,   // first octet of cell seen
    output logic              rx_out_valid, // received octet pulse
    output fcdl_octet_s       rx_out,       // received octet
    input  wire fcdl_dma_id_s dma_id,       // current dma requester
    input  wire logic         dma_err,      // dma transfer error pulse
    output logic      [5:0]   dma_requester_number, // requester output
    output logic      [5:0]   dma_err_number        // captured on error
);
    // ==========================================================
    // pin synchronisers
    logic [11:0] sync_a;
    logic [11:0] sync_b;
    logic        tx_clk_d;
    logic        rx_clk_d;
    logic        tx_edge;
    logic        rx_edge;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_a   <= '0;
            sync_b   <= '0;
            tx_clk_d <= 1'b0;
            rx_clk_d <= 1'b0;
        end else if (ce) begin
            sync_a   <= {tx_link_clk, rx_link_clk, rx_data, rx_enb_n, rx_soc};
            sync_b   <= sync_a;
            tx_clk_d <= sync_b[11];
            rx_clk_d <= sync_b[10];
        end
    end

    // rising edges of the sampled link clocks
    always_comb begin
        tx_edge = sync_b[11] && !tx_clk_d;
        rx_edge = sync_b[10] && !rx_clk_d;
    end

    logic rx_dv_a;
    logic rx_dv_b;

    // data valid passes its own two flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_dv_a <= 1'b0;
            rx_dv_b <= 1'b0;
        end else if (ce) begin
            rx_dv_a <= rx_dv;
            rx_dv_b <= rx_dv_a;
        end
    end

    // ==========================================================
    // transmit fifo
    logic       fifo_valid;
    logic       fifo_pop;
    logic [7:0] fifo_data;

    fcdl_fifo #(
        .W (FCDL_FIFO_WIDTH),
        .D (FCDL_FIFO_DEPTH)
    ) u_tx_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (tx_in_valid),
        .in_ready  (tx_in_ready),
        .in_data   (tx_in_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // ==========================================================
    // transmit lane
    logic [5:0] tx_cnt;
    logic       tx_payload;
    logic [7:0] tx_sr;
    logic [2:0] tx_sub;
    logic [5:0] next_tx_cnt;
    logic       next_tx_payload;
    logic [7:0] next_tx_sr;
    logic [2:0] next_tx_sub;
    logic [7:0] next_tx_data;
    logic       next_tx_soc;
    logic       next_tx_en;
    logic [2:0] tx_step;
    logic [7:0] tx_cur;
    logic       tx_start;

    // next transmit state, one unit per link edge
    always_comb begin
        next_tx_cnt     = tx_cnt;
        next_tx_payload = tx_payload;
        next_tx_sr      = tx_sr;
        next_tx_sub     = tx_sub;
        next_tx_data    = tx_data;
        next_tx_soc     = tx_soc;
        next_tx_en      = tx_en;
        fifo_pop        = 1'b0;
        tx_step         = (line_mode == FCDL_MODE_NIBBLE) ? FCDL_STEP_NIBBLE : FCDL_STEP_SERIAL;
        tx_start        = tx_sub == 3'h0;
        tx_cur          = tx_start ? fifo_data : tx_sr;
        if (tx_edge) begin
            unique case (line_mode)
                FCDL_MODE_UTOPIA: begin
                    next_tx_soc = tx_cnt == FCDL_CELL_FIRST;
                    if (tx_cnt == FCDL_CELL_FIRST) begin
                        next_tx_payload = fifo_valid;
                    end
                    if (next_tx_payload && fifo_valid) begin
                        next_tx_data = fifo_data;
                        fifo_pop     = 1'b1;
                    end else begin
                        next_tx_data = FCDL_IDLE_OCTET;
                    end
                    next_tx_cnt = (tx_cnt == FCDL_CELL_LAST) ? FCDL_CELL_FIRST
                                                             : tx_cnt + 6'h01;
                    next_tx_en  = 1'b1;
                end
                FCDL_MODE_NIBBLE, FCDL_MODE_SERIAL: begin
                    next_tx_soc = 1'b0;
                    if (tx_start && !fifo_valid) begin
                        next_tx_en   = 1'b0;
                        next_tx_data = FCDL_RST_OCTET;
                    end else begin
                        fifo_pop   = tx_start;
                        next_tx_en = 1'b1;
                        if (line_mode == FCDL_MODE_NIBBLE) begin
                            next_tx_data = {4'h0, tx_cur[3:0]};
                        end else begin
                            next_tx_data = {7'h00, tx_cur[0]};
                        end
                        next_tx_sr  = tx_cur >> tx_step;
                        next_tx_sub = tx_sub + tx_step;
                    end
                end
                default: begin
                    next_tx_en   = 1'b0;
                    next_tx_data = FCDL_RST_OCTET;
                end
            endcase
        end
    end

    // transmit registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_cnt     <= FCDL_CELL_FIRST;
            tx_payload <= 1'b0;
            tx_sr      <= FCDL_RST_OCTET;
            tx_sub     <= 3'h0;
            tx_data    <= FCDL_RST_OCTET;
            tx_soc     <= 1'b0;
            tx_en      <= 1'b0;
        end else if (ce) begin
            tx_cnt     <= next_tx_cnt;
            tx_payload <= next_tx_payload;
            tx_sr      <= next_tx_sr;
            tx_sub     <= next_tx_sub;
            tx_data    <= next_tx_data;
            tx_soc     <= next_tx_soc;
            tx_en      <= next_tx_en;
        end
    end

    // ==========================================================
    // receive lane
    logic        rx_enb_seen;
    logic [5:0]  rx_cnt;
    logic [7:0]  rx_sr;
    logic [2:0]  rx_sub;
    logic        next_rx_enb_seen;
    logic [5:0]  next_rx_cnt;
    logic [7:0]  next_rx_sr;
    logic [2:0]  next_rx_sub;
    logic        next_rx_valid;
    fcdl_octet_s next_rx_out;
    logic        next_rx_soc_out;
    logic [7:0]  rx_pins;

    // next receive state, sampled at link edges
    always_comb begin
        rx_pins          = sync_b[9:2];
        next_rx_enb_seen = rx_enb_seen;
        next_rx_cnt      = rx_cnt;
        next_rx_sr       = rx_sr;
        next_rx_sub      = rx_sub;
        next_rx_valid    = 1'b0;
        next_rx_out      = rx_out;
        next_rx_soc_out  = 1'b0;
        if (rx_edge) begin
            unique case (line_mode)
                FCDL_MODE_UTOPIA: begin
                    next_rx_enb_seen = !sync_b[1];
                    if (rx_enb_seen) begin
                        next_rx_valid    = 1'b1;
                        next_rx_out.data = rx_pins;
                        if (sync_b[0]) begin
                            next_rx_cnt = 6'h01;
                        end else begin
                            next_rx_cnt = (rx_cnt == FCDL_CELL_LAST + 6'h01) ? 6'h01
                                                                             : rx_cnt + 6'h01;
                        end
                        next_rx_out.first = sync_b[0] || (rx_cnt == FCDL_CELL_LAST + 6'h01);
                        next_rx_soc_out   = next_rx_out.first;
                    end
                end
                FCDL_MODE_NIBBLE: begin
                    if (!rx_dv_b) begin
                        next_rx_sub = 3'h0;
                    end else begin
                        next_rx_sr  = {rx_pins[3:0], rx_sr[7:4]};
                        next_rx_sub = rx_sub + FCDL_STEP_NIBBLE;
                        if (rx_sub == 3'h4) begin
                            next_rx_valid = 1'b1;
                            next_rx_out   = '{data: {rx_pins[3:0], rx_sr[7:4]}, first: 1'b0};
                        end
                    end
                end
                FCDL_MODE_SERIAL: begin
                    next_rx_sr  = {rx_pins[0], rx_sr[7:1]};
                    next_rx_sub = rx_sub + FCDL_STEP_SERIAL;
                    if (rx_sub == 3'h7) begin
                        next_rx_valid = 1'b1;
                        next_rx_out   = '{data: {rx_pins[0], rx_sr[7:1]}, first: 1'b0};
                    end
                end
                default: begin
                    next_rx_sub = 3'h0;
                end
            endcase
        end
    end

    // receive registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_enb_seen  <= 1'b0;
            rx_cnt       <= FCDL_CELL_FIRST;
            rx_sr        <= FCDL_RST_OCTET;
            rx_sub       <= 3'h0;
            rx_out_valid <= 1'b0;
            rx_out       <= '0;
            rx_soc_out   <= 1'b0;
        end else if (ce) begin
            rx_enb_seen  <= next_rx_enb_seen;
            rx_cnt       <= next_rx_cnt;
            rx_sr        <= next_rx_sr;
            rx_sub       <= next_rx_sub;
            rx_out_valid <= next_rx_valid;
            rx_out       <= next_rx_out;
            rx_soc_out   <= next_rx_soc_out;
        end
    end

    // ==========================================================
    // dma requester number and error capture
    logic [5:0] next_dma_num;
    logic [5:0] next_dma_err;

    always_comb begin
        next_dma_num = {dma_id.dir_rx, dma_id.sub_block};
        next_dma_err = dma_err ? dma_requester_number : dma_err_number;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dma_requester_number <= FCDL_RST_DMA_NUM;
            dma_err_number       <= FCDL_RST_DMA_NUM;
        end else if (ce) begin
            dma_requester_number <= next_dma_num;
            dma_err_number       <= next_dma_err;
        end
    end
endmodule : fcdl_lanes

`default_nettype wire

// ==== test/fcdl_lanes_checker.sv ====
/*
 * fcdl_lanes_checker: port assertions for fcdl_lanes.
 * Assumes one core clock domain; bound to the design by the bind below.
 */
`timescale 1ns/1ps
`default_nettype none
module fcdl_lanes_checker
    import fcdl_pkg::*;
(
    input wire logic         clock,                // core clock
    input wire logic         sys_rst,              // sync reset
    input wire logic         ce,                   // clock enable
    input wire fcdl_mode_e   line_mode,            // line mode
    input wire logic [7:0]   tx_data,              // tx lines
    input wire logic         tx_en,                // tx enable
    input wire logic         rx_soc_out,           // rx first octet
    input wire logic         rx_out_valid,         // rx octet pulse
    input wire fcdl_octet_s  rx_out,               // rx octet
    input wire fcdl_dma_id_s dma_id,               // dma requester
    input wire logic         dma_err,              // dma error pulse
    input wire logic [5:0]   dma_requester_number, // requester out
    input wire logic [5:0]   dma_err_number        // captured number
);
    // ==========================================================
    // assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    dma_code_a: assert property (
        $past(ce) && !$past(sys_rst) |-> dma_requester_number[4:0] == $past(dma_id.sub_block))
        else $error("requester code mismatch");
    dma_dir_a: assert property (
        $past(ce) && !$past(sys_rst) |-> dma_requester_number[5] == $past(dma_id.dir_rx))
        else $error("requester direction mismatch");
    err_capture_a: assert property (
        $past(ce) && $past(dma_err) && !$past(sys_rst) |->
        dma_err_number == $past(dma_requester_number))
        else $error("error number not captured");
    err_hold_a: assert property (
        !($past(ce) && $past(dma_err)) && !$past(sys_rst) |-> $stable(dma_err_number))
        else $error("error number changed without error");
    soc_first_a: assert property (
        rx_soc_out |-> rx_out_valid && rx_out.first)
        else $error("start of cell without first octet");
    rx_pulse_a: assert property (
        rx_out_valid |=> !rx_out_valid)
        else $error("receive pulse too long");
    nib_lanes_a: assert property (
        line_mode == FCDL_MODE_NIBBLE |-> tx_data[7:4] == 4'h0)
        else $error("nibble mode upper lanes driven");
    ser_lane_a: assert property (
        line_mode == FCDL_MODE_SERIAL |-> tx_data[7:1] == 7'h00)
        else $error("serial mode extra lanes driven");
    idle_zero_a: assert property (
        line_mode != FCDL_MODE_UTOPIA && !tx_en |-> tx_data == 8'h00)
        else $error("data without transmit enable");
    cell_stream_a: assert property (
        line_mode == FCDL_MODE_UTOPIA && $past(tx_en) |-> tx_en)
        else $error("cell stream stopped");
endmodule : fcdl_lanes_checker

bind fcdl_lanes fcdl_lanes_checker u_chk (.clock, .sys_rst, .ce, .line_mode, .tx_data,
    .tx_en, .rx_soc_out, .rx_out_valid, .rx_out, .dma_id, .dma_err,
    .dma_requester_number, .dma_err_number);
`default_nettype wire

// ==== test/fcdl_phy_model.sv ====
/*
 * fcdl_phy_model: far-side phy making both link clocks and receive traffic.
 * Assumes the bench fills q and calls send; tx_run starts the tx link clock.
 */
`timescale 1ns/1ps
`default_nettype none
module fcdl_phy_model (
    output logic       tx_link_clk, // tx link clock
    output logic       rx_link_clk, // rx link clock
    output logic [7:0] rx_data,     // rx lines
    output logic       rx_enb_n,    // rx enable, low
    output logic       rx_soc,      // rx start of cell
    output logic       rx_dv        // nibble data valid
);
    logic       tx_run = 1'b0; // tx link clock runs only when set
    logic [7:0] q[$];          // octets to send
    initial {tx_link_clk, rx_link_clk, rx_enb_n, rx_soc, rx_dv, rx_data} = 13'h0400;
    // tx link clock, 64 ns, still outside traffic
    always #32 tx_link_clk = tx_run ? ~tx_link_clk : 1'b0;
    // send q in units of w bits, changing lines on the falling link edge
    task automatic send(input int w);
        int         n;
        logic [7:0] last;
        n = q.size() * (8 / w);
        // only utopia needs the trailing edge that samples the last enabled octet
        for (int i = 0; i < n + (w == 8); i++) begin
            last = rx_data;
            if (w == 8) begin
                rx_enb_n = (i == n);
                rx_soc = (i == 1);
                rx_data = (i > 0) ? q[i-1] : ~last;
            end else begin
                rx_dv = (i < n);
                rx_data = (i < n) ? 8'((q[i*w/8] >> (i*w%8)) & ((1 << w) - 1)) : ~last;
            end
            #32 rx_link_clk = 1'b1;
            #32 rx_link_clk = 1'b0;
        end
        {rx_enb_n, rx_soc, rx_dv} = 3'h4;
        rx_data = ~rx_data;
        q.delete();
    endtask : send
endmodule : fcdl_phy_model
`default_nettype wire

// ==== test/fcdl_lanes_test.sv ====
/*
 * fcdl_lanes_test: self-checking bench for fcdl_lanes with a phy model.
 * Assumes fcdl_pkg, fcdl_lanes and fcdl_phy_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module fcdl_lanes_test;
    import fcdl_pkg::*;
    logic         clock = 1'b0, sys_rst = 1'b1, ce = 1'b1;
    logic         tx_in_valid = 1'b0, dma_err = 1'b0;
    logic [7:0]   tx_in_data = 8'h00;
    fcdl_mode_e   line_mode = FCDL_MODE_UTOPIA;
    fcdl_dma_id_s dma_id = '0;
    logic         tx_in_ready, tx_soc, tx_en, rx_soc_out, rx_out_valid;
    logic         tx_link_clk, rx_link_clk, rx_enb_n, rx_soc, rx_dv;
    logic [7:0]   tx_data, rx_data;
    fcdl_octet_s  rx_out;
    logic [5:0]   dma_requester_number, dma_err_number;
    int           n_errors = 0, n_checks = 0;
    logic [7:0]   exp_q[$];
    fcdl_octet_s  got_q[$];
    logic         soc_q[$];

    fcdl_lanes dut (.*);
    fcdl_phy_model phy (.*);
    // ==========================================================
    // clock, collector and shared tasks
    always #4 clock = ~clock;
    // collect each received octet with its start-of-cell output
    always @(posedge clock) begin
        if (rx_out_valid === 1'b1) begin
            got_q.push_back(rx_out);
            soc_q.push_back(rx_soc_out);
        end
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic restart(input fcdl_mode_e m);
        sys_rst = 1'b1;
        line_mode = m;
        tick(20);
        sys_rst = 1'b0;
    endtask : restart
    task automatic push_n(input int n);
        repeat (n) begin
            tx_in_data = 8'($urandom);
            tx_in_valid = 1'b1;
            exp_q.push_back(tx_in_data);
            tick(1);
        end
        tx_in_valid = 1'b0;
    endtask : push_n
    // ==========================================================
    // tests
    task automatic tx_cells();
        int         cnt;
        bit         pay;
        logic [7:0] want;
        cnt = -1;
        pay = 1'b0;
        push_n(16);
        check(9'(tx_in_ready), 9'h000);
        phy.tx_run = 1'b1;
        repeat (110) begin
            @(posedge tx_link_clk);
            if (cnt >= 0 || tx_soc === 1'b1) begin
                check(9'(tx_soc), 9'(cnt == 53 || cnt < 0));
                if (tx_soc === 1'b1) cnt = 0;
                if (cnt == 0) pay = (exp_q.size() > 0);
                want = (pay && exp_q.size() > 0) ? exp_q.pop_front() : FCDL_IDLE_OCTET;
                check({tx_en, tx_data}, {1'b1, want});
                cnt++;
            end
        end
        phy.tx_run = 1'b0;
        tick(1);
        $display("test utopia transmit done");
    endtask : tx_cells
    task automatic tx_units(input int w);
        int k;
        k = 0;
        push_n(2);
        phy.tx_run = 1'b1;
        repeat (16 / w + 3) begin
            @(posedge tx_link_clk);
            if (k >= 16 / w) check({tx_en, tx_data}, 9'h000);
            else if (tx_en === 1'b1 || k > 0)
                check({tx_en, tx_data}, {1'b1, 8'((exp_q[k*w/8] >> (k*w%8)) & ((1 << w) - 1))});
            if (tx_en === 1'b1 || k > 0) k++;
        end
        phy.tx_run = 1'b0;
        tick(1);
        exp_q.delete();
        $display("test transmit width %0d done", w);
    endtask : tx_units
    task automatic tx_off();
        push_n(1);
        phy.tx_run = 1'b1;
        repeat (3) begin
            @(posedge tx_link_clk);
            check({tx_en, tx_data}, 9'h000);
        end
        phy.tx_run = 1'b0;
        tick(1);
        exp_q.delete();
        $display("test unused line mode done");
    endtask : tx_off
    task automatic rx_units(input int w, input int n);
        logic [7:0] sent[$];
        for (int i = 0; i < n; i++) sent.push_back(8'($urandom));
        phy.q = sent;
        phy.send(w);
        tick(20);
        check(9'(got_q.size()), 9'(n));
        foreach (sent[i]) begin
            check({got_q[i].data, got_q[i].first}, {sent[i], w == 8 && i % 53 == 0});
            check(9'(soc_q[i]), 9'(w == 8 && i % 53 == 0));
        end
        got_q.delete();
        soc_q.delete();
        $display("test receive width %0d done", w);
    endtask : rx_units
    task automatic dma_ids();
        logic [5:0] num, err;
        num = FCDL_RST_DMA_NUM;
        err = FCDL_RST_DMA_NUM;
        repeat (40) begin
            dma_id = 6'($urandom);
            dma_err = 1'($urandom);
            ce = ($urandom_range(3) != 0);
            tick(1);
            if (ce && dma_err) err = num;
            if (ce) num = {dma_id.dir_rx, dma_id.sub_block};
            check(9'(dma_requester_number), 9'(num));
            check(9'(dma_err_number), 9'(err));
        end
        ce = 1'b1;
        dma_err = 1'b0;
        $display("test dma requester done");
    endtask : dma_ids
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // ==========================================================
    // main sequence and watchdog
    initial begin
        void'($urandom(42562));
        restart(FCDL_MODE_UTOPIA);
        check({tx_in_ready, tx_data}, 9'h100);
        tx_cells();
        restart(FCDL_MODE_NIBBLE);
        tx_units(4);
        restart(FCDL_MODE_SERIAL);
        tx_units(1);
        restart(FCDL_MODE_UTOPIA);
        rx_units(8, 106);
        restart(FCDL_MODE_NIBBLE);
        rx_units(4, 5);
        restart(FCDL_MODE_SERIAL);
        rx_units(1, 5);
        restart(fcdl_mode_e'(2'h3));
        tx_off();
        dma_ids();
        tally_and_finish();
    end
    initial begin
        #200_000;
        n_errors++;
        tally_and_finish();
    end
endmodule : fcdl_lanes_test
`default_nettype wire
